// *** shared/dvr_defines.svh ***
// register offsets, field positions, reset values and timing figures of the volume ramp block
`ifndef DVR_DEFINES_SVH
`define DVR_DEFINES_SVH
// register indices; each register sits on a word, at four times its index on the bus
`define DVR_OFF_LEVEL      8'h4C
`define DVR_OFF_RAMP       8'h4E
`define DVR_OFF_EMERG      8'h4F
`define DVR_OFF_SILENCE    8'h50
`define DVR_OFF_RUNLEN     8'h51
`define DVR_OFF_STATUS     8'h60
`define DVR_RST_LEVEL      8'h30
`define DVR_RST_RAMP       8'h33
`define DVR_RST_EMERG      8'h30
`define DVR_RST_SILENCE    8'h07
`define DVR_RST_RUNLEN     8'h00
`define DVR_CODE_UNITY     8'h30
`define DVR_CODE_MUTE      8'hFF
`define DVR_FALL_IVL_HI    7
`define DVR_FALL_INC_HI    5
`define DVR_RISE_IVL_HI    3
`define DVR_RISE_INC_HI    1
`define DVR_SIL_LEFT       0
`define DVR_SIL_RIGHT      1
`define DVR_SIL_BOTH       2
`define DVR_RUN_LEFT_HI    6
`define DVR_RUN_RIGHT_HI   2
`define DVR_IVL_INSTANT    2'b11
// zero-run limits in sample periods, 11.5 ms .. 5.33 s at 96 kHz
`define DVR_RUN_LIM0       20'h00450
`define DVR_RUN_LIM1       20'h013E0
`define DVR_RUN_LIM2       20'h027F0
`define DVR_RUN_LIM3       20'h063F0
`define DVR_RUN_LIM4       20'h0C8A0
`define DVR_RUN_LIM5       20'h18F60
`define DVR_RUN_LIM6       20'h3E760
`define DVR_RUN_LIM7       20'h7CEC0
`endif

// *** shared/dvr_pkg.sv ***
// types of the volume ramp block
package dvr_pkg;
  typedef enum logic [1:0]
  {
    DVR_HOLD = 2'b00,
    DVR_RISE = 2'b01,
    DVR_FALL = 2'b10,
    DVR_EMRG = 2'b11
  } dvr_ramp_t;
endpackage

// *** hw/dvr_zero_run.sv ***
// zero-run detector for one channel, qualifies the channel for auto silence
`timescale 1ns/100ps
`default_nettype none
`include "dvr_defines.svh"
module dvr_zero_run
  import dvr_pkg::*;
#(
  parameter int SW = 24
)
(
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          tick,
  input  wire logic [SW-1:0] sample,
  input  wire logic [2:0]    run_sel,
  output logic               qualified
);
  logic [19:0] run_count;
  logic [19:0] run_limit;
  // run lengths in sample periods at 96 kHz (11.5 ms .. 5.33 s)
  always_comb
  begin
    case (run_sel)
      3'h0:    run_limit = `DVR_RUN_LIM0;
      3'h1:    run_limit = `DVR_RUN_LIM1;
      3'h2:    run_limit = `DVR_RUN_LIM2;
      3'h3:    run_limit = `DVR_RUN_LIM3;
      3'h4:    run_limit = `DVR_RUN_LIM4;
      3'h5:    run_limit = `DVR_RUN_LIM5;
      3'h6:    run_limit = `DVR_RUN_LIM6;
      default: run_limit = `DVR_RUN_LIM7;
    endcase
  end
  // count consecutive zero samples; saturates at the limit
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      run_count <= 20'h00000;
    else if (tick)
      run_count <= (sample != '0) ? 20'h00000 :
                   (run_count >= run_limit) ? run_count : run_count + 20'h00001;
  end
  assign qualified = (run_count >= run_limit); // R12
endmodule
`default_nettype wire

// *** hw/dvr_volume_ramp.sv ***
// stereo digital volume ramp with emergency fall and auto silence, APB registers
`timescale 1ns/100ps
`default_nettype none
`include "dvr_defines.svh"
// Overview of operation
// R1: one 8-bit code scales both channels
// R2: 0x00 +24dB, 0x30 unity, 0xFF mute
// R3: fall interval 1,2,4 periods or instant
// R4: fall step 4,2,1,0.5 dB
// R5: rise interval 1,2,4 periods or instant
// R6: rise step 4,2,1,0.5 dB
// R7: emergency fall interval, instant at 11
// R8: emergency fall step, independent setting
// R9: bit0 enables left auto silence
// R10: bit1 enables right auto silence
// R11: bit2 silences only when both qualify
// R12: qualify after programmed zero run
// R13: ramp toward target, stop exactly; an instant fall goes straight to mute (0xFF) instead of stopping at the target
module dvr_volume_ramp
  import dvr_pkg::*;
#(
  parameter int SW = 24
)
(
  input  wire logic          CLK,
  input  wire logic          RST,
  input  wire logic          PSEL,
  input  wire logic          PENABLE,
  input  wire logic          PWRITE,
  input  wire logic [9:0]    PADDR,
  input  wire logic [31:0]   PWDATA,
  output logic [31:0]        PRDATA,
  output logic               PREADY,
  output logic               PSLVERR,
  input  wire logic          SAMPLE_TICK,
  input  wire logic [SW-1:0] LEFT_IN,
  input  wire logic [SW-1:0] RIGHT_IN,
  input  wire logic          EMERGENCY,
  output logic [7:0]         APPLIED_CODE,
  output logic               LEFT_SILENT,
  output logic               RIGHT_SILENT
);
  // ****************************************
  // register file
  // ****************************************
  logic [7:0] master_gain_code;
  logic [7:0] ramp_rates;
  logic [7:0] emerg_rates;
  logic [7:0] silence_ctrl;
  logic [7:0] run_lengths;
  logic       emerg_s1;
  logic       emerg_s2;
  logic [7:0] applied;
  logic [1:0] ivl_count;
  dvr_ramp_t  mode;

  wire        acc       = PSEL & PENABLE;
  wire        wr        = acc & PWRITE;
  // byte address is four times the index, so a misaligned address hits nothing
  wire        hit_level = (PADDR == {`DVR_OFF_LEVEL, 2'b00});
  wire        hit_ramp  = (PADDR == {`DVR_OFF_RAMP, 2'b00});
  wire        hit_emerg = (PADDR == {`DVR_OFF_EMERG, 2'b00});
  wire        hit_sil   = (PADDR == {`DVR_OFF_SILENCE, 2'b00});
  wire        hit_run   = (PADDR == {`DVR_OFF_RUNLEN, 2'b00});
  wire        hit_stat  = (PADDR == {`DVR_OFF_STATUS, 2'b00});
  wire        hit_any   = hit_level | hit_ramp | hit_emerg | hit_sil | hit_run | hit_stat;

  // zero-wait slave; unmapped addresses and status writes answer with an error
  assign PREADY  = 1'b1;
  assign PSLVERR = acc & (~hit_any | (PWRITE & hit_stat));

  // software writes take effect at the access edge
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      master_gain_code <= `DVR_RST_LEVEL;
      ramp_rates       <= `DVR_RST_RAMP;
      emerg_rates      <= `DVR_RST_EMERG;
      silence_ctrl     <= `DVR_RST_SILENCE;
      run_lengths      <= `DVR_RST_RUNLEN;
    end
    else if (wr)
    begin
      if (hit_level) master_gain_code <= PWDATA[7:0]; // R1
      if (hit_ramp)  ramp_rates       <= PWDATA[7:0];
      if (hit_emerg) emerg_rates      <= PWDATA[7:0];
      if (hit_sil)   silence_ctrl     <= PWDATA[7:0];
      if (hit_run)   run_lengths      <= PWDATA[7:0];
    end
  end

  // read mux; status shows the ramp mode and silence flags
  wire [7:0] rd_byte =
    hit_level ? master_gain_code :
    hit_ramp  ? ramp_rates :
    hit_emerg ? emerg_rates :
    hit_sil   ? silence_ctrl :
    hit_run   ? run_lengths :
    hit_stat  ? {LEFT_SILENT, RIGHT_SILENT, 4'h0, mode} : 8'h00;

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      PRDATA <= 32'h00000000;
    else
      PRDATA <= {24'h000000, rd_byte};
  end

  // ****************************************
  // emergency input synchroniser
  // ****************************************
  // the pin is asynchronous, so only the second stage is looked at
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      emerg_s1 <= 1'b0;
      emerg_s2 <= 1'b0;
    end
    else
    begin
      emerg_s1 <= EMERGENCY;
      emerg_s2 <= emerg_s1;
    end
  end

  // ****************************************
  // ramp engine
  // ****************************************
  // step in half-dB codes: 00 -> 4 dB .. 11 -> 0.5 dB
  function automatic logic [7:0] step_codes(input logic [1:0] sel);
    step_codes = 8'h08 >> sel;
  endfunction

  // interval in sample periods minus one
  function automatic logic [1:0] ivl_last(input logic [1:0] sel);
    ivl_last = (sel == 2'b00) ? 2'h0 : (sel == 2'b01) ? 2'h1 : 2'h3;
  endfunction

  // in emergency the target is full mute, otherwise the programmed code
  wire [7:0] target    = emerg_s2 ? `DVR_CODE_MUTE : master_gain_code;
  wire       falling   = applied < target;  // higher code means lower gain
  wire       rising    = applied > target;
  wire [1:0] fall_ivl  = emerg_s2 ? emerg_rates[`DVR_FALL_IVL_HI -: 2]
                                  : ramp_rates[`DVR_FALL_IVL_HI -: 2];            // R3 R7
  wire [1:0] fall_inc  = emerg_s2 ? emerg_rates[`DVR_FALL_INC_HI -: 2]
                                  : ramp_rates[`DVR_FALL_INC_HI -: 2];            // R4 R8
  wire [1:0] rise_ivl  = ramp_rates[`DVR_RISE_IVL_HI -: 2];                      // R5
  wire [1:0] rise_inc  = ramp_rates[`DVR_RISE_INC_HI -: 2];                      // R6
  wire [1:0] cur_ivl   = falling ? fall_ivl : rise_ivl;
  wire       instant   = (cur_ivl == `DVR_IVL_INSTANT);
  wire       update    = SAMPLE_TICK & (instant | (ivl_count >= ivl_last(cur_ivl)));
  wire [7:0] gap_down  = target - applied;
  wire [7:0] gap_up    = applied - target;
  wire [7:0] fstep     = step_codes(fall_inc);
  wire [7:0] rstep     = step_codes(rise_inc);

  // instant fall goes straight to mute; instant rise restores the target
  wire [7:0] next_applied =
    ~update               ? applied :
    (falling & instant)   ? `DVR_CODE_MUTE :                                       // R3 R7
    falling               ? ((gap_down <= fstep) ? target : applied + fstep) :       // R13
    (rising & instant)    ? target :                                                // R5
    rising                ? ((gap_up <= rstep) ? target : applied - rstep) :        // R13
                            applied;

  wire dvr_ramp_t next_mode = emerg_s2 & falling ? DVR_EMRG :
                              falling ? DVR_FALL : rising ? DVR_RISE : DVR_HOLD;

  // interval counter restarts after every update
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      applied   <= `DVR_RST_LEVEL;
      ivl_count <= 2'h0;
      mode      <= DVR_HOLD;
    end
    else
    begin
      applied   <= next_applied; // R2
      mode      <= next_mode;
      if (update | ~(falling | rising))
        ivl_count <= 2'h0;
      else if (SAMPLE_TICK)
        ivl_count <= ivl_count + 2'h1;
    end
  end
  assign APPLIED_CODE = applied; // R1

  // ****************************************
  // auto silence
  // ****************************************
  logic left_q;
  logic right_q;
  logic left_sil;
  logic right_sil;

  dvr_zero_run #(.SW(SW)) u_left
  (
    .clk       (CLK),
    .rst       (RST),
    .tick      (SAMPLE_TICK),
    .sample    (LEFT_IN),
    .run_sel   (run_lengths[`DVR_RUN_LEFT_HI -: 3]),
    .qualified (left_q)
  );

  dvr_zero_run #(.SW(SW)) u_right
  (
    .clk       (CLK),
    .rst       (RST),
    .tick      (SAMPLE_TICK),
    .sample    (RIGHT_IN),
    .run_sel   (run_lengths[`DVR_RUN_RIGHT_HI -: 3]),
    .qualified (right_q)
  );

  // joint mode waits for both enabled channels to qualify together
  wire left_ok  = silence_ctrl[`DVR_SIL_LEFT] & left_q;    // R9 R12
  wire right_ok = silence_ctrl[`DVR_SIL_RIGHT] & right_q;  // R10 R12
  wire both     = silence_ctrl[`DVR_SIL_BOTH];
  wire next_left_sil  = both ? (left_ok & right_ok) : left_ok;   // R11
  wire next_right_sil = both ? (left_ok & right_ok) : right_ok;  // R11

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      left_sil  <= 1'b0;
      right_sil <= 1'b0;
    end
    else
    begin
      left_sil  <= next_left_sil;
      right_sil <= next_right_sil;
    end
  end
  assign LEFT_SILENT  = left_sil;
  assign RIGHT_SILENT = right_sil;

  // ****************************************
  // checks
  // ****************************************
  chk_code_holds_idle: assert property (@(posedge CLK) disable iff (RST) // R13
    !SAMPLE_TICK |=> applied == $past(applied)) else $error("code moved without tick");
  chk_no_overshoot_fall: assert property (@(posedge CLK) disable iff (RST) // R13
    (falling && !instant && !$changed(target)) |=> applied <= $past(target))
    else $error("fall overshoot");
  chk_no_overshoot_rise: assert property (@(posedge CLK) disable iff (RST) // R13
    (rising && !$changed(target)) |=> applied >= $past(target)) else $error("rise overshoot");
  chk_instant_fall_mute: assert property (@(posedge CLK) disable iff (RST) // R3
    (SAMPLE_TICK && falling && fall_ivl == 2'b11) |=> applied == 8'hFF)
    else $error("instant fall did not mute");
  chk_instant_rise_set: assert property (@(posedge CLK) disable iff (RST) // R5
    (SAMPLE_TICK && rising && rise_ivl == 2'b11) |=> applied == $past(target))
    else $error("instant rise missed target");
  chk_fall_step_size: assert property (@(posedge CLK) disable iff (RST) // R4
    (update && falling && !instant && gap_down > fstep) |=> applied == $past(applied) + $past(fstep))
    else $error("fall step wrong");
  chk_rise_step_size: assert property (@(posedge CLK) disable iff (RST) // R6
    (update && rising && !instant && gap_up > rstep) |=> applied == $past(applied) - $past(rstep))
    else $error("rise step wrong");
  chk_emerg_to_mute: assert property (@(posedge CLK) disable iff (RST) // R7
    (SAMPLE_TICK && emerg_s2 && applied != `DVR_CODE_MUTE
     && emerg_rates[`DVR_FALL_IVL_HI -: 2] == `DVR_IVL_INSTANT)
    |=> applied == `DVR_CODE_MUTE) else $error("emergency instant mute missed");
  chk_left_enable: assert property (@(posedge CLK) disable iff (RST) // R9
    !silence_ctrl[0] |=> !LEFT_SILENT) else $error("left silenced while disabled");
  chk_joint_silence: assert property (@(posedge CLK) disable iff (RST) // R11
    both |=> LEFT_SILENT == RIGHT_SILENT) else $error("joint silence split");
endmodule
`default_nettype wire

// *** verif/tb_dvr_volume_ramp.sv ***
// self-checking testbench for the stereo volume ramp block
`timescale 1ns/100ps
`default_nettype none
`include "dvr_defines.svh"
module tb_dvr_volume_ramp;
  logic        CLK, RST, PSEL, PENABLE, PWRITE, SAMPLE_TICK, EMERGENCY;
  logic [9:0]  PADDR;
  logic [7:0]  APPLIED_CODE;
  logic [31:0] PWDATA, PRDATA, rd;
  logic        PREADY, PSLVERR, LEFT_SILENT, RIGHT_SILENT, er;
  logic [23:0] LEFT_IN, RIGHT_IN;
  int          mismatches, checks, mv;

  dvr_volume_ramp #(.SW(24)) DUT (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .SAMPLE_TICK(SAMPLE_TICK), .LEFT_IN(LEFT_IN), .RIGHT_IN(RIGHT_IN),
    .EMERGENCY(EMERGENCY), .APPLIED_CODE(APPLIED_CODE), .LEFT_SILENT(LEFT_SILENT),
    .RIGHT_SILENT(RIGHT_SILENT));

  // free-running 100 MHz clock
  initial
  begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end

  // ****************
  // helpers
  // ****************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // one apb transfer to register index a; an idle edge first keeps psel from
  // being lowered and raised in one time step between two calls
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= {a, 2'b00};
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    @(posedge CLK);
    while (PREADY !== 1'b1 && n < 20)
    begin
      @(posedge CLK);
      n++;
    end
    if (PREADY !== 1'b1)
    begin
      mismatches++;
      print_verdict();
    end
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  // one sample period; two spare cycles let the registered code settle
  task automatic tick();
    SAMPLE_TICK <= 1'b1;
    @(posedge CLK);
    SAMPLE_TICK <= 1'b0;
    repeat (2) @(posedge CLK);
  endtask

  function automatic logic [7:0] toward(input logic [7:0] p, input logic [7:0] t, input int s);
    if (t > p)
      return (int'(t - p) > s) ? 8'(p + s) : t;
    return (int'(p - t) > s) ? 8'(p - s) : t;
  endfunction

  // a move must be one whole step, clamped at the goal
  task automatic st(input logic [7:0] t, input int s);
    logic [7:0] p;
    p = APPLIED_CODE;
    tick();
    if (APPLIED_CODE !== p)
    begin
      mv++;
      chk(APPLIED_CODE, toward(p, t, s));
    end
  endtask

  task automatic ramp(input logic [7:0] t, input int s, input int n, input int m);
    apb(1'b1, `DVR_OFF_LEVEL, {24'h0, t});
    mv = 0;
    repeat (n) st(t, s);
    chk(mv, m);
  endtask

  // ****************
  // scenarios
  // ****************
  task automatic t_regs();
    logic [7:0] a [5] = '{`DVR_OFF_LEVEL, `DVR_OFF_RAMP, `DVR_OFF_EMERG, `DVR_OFF_SILENCE,
                          `DVR_OFF_RUNLEN};
    logic [7:0] v [5] = '{`DVR_RST_LEVEL, `DVR_RST_RAMP, `DVR_RST_EMERG, `DVR_RST_SILENCE,
                          `DVR_RST_RUNLEN};
    for (int i = 0; i < 5; i++)
    begin
      apb(1'b0, a[i], 32'h0);
      chk(rd, {24'h0, v[i]});
    end
    chk(APPLIED_CODE, `DVR_CODE_UNITY);
    apb(1'b0, `DVR_OFF_STATUS, 32'h0);
    chk(rd, 32'h00);
    apb(1'b1, `DVR_OFF_EMERG, 32'hFFFF_FFA5);
    apb(1'b0, `DVR_OFF_EMERG, 32'h0);
    chk(rd, 32'hA5);
    apb(1'b0, 8'h40, 32'h0);
    chk(er, 1'b1);
    chk(rd, 32'h0);
    apb(1'b1, `DVR_OFF_STATUS, 32'hFF);
    chk(er, 1'b1);
    $display("t_regs done");
  endtask

  task automatic t_ramp();
    apb(1'b1, `DVR_OFF_RAMP, 32'h05);
    ramp(8'h50, 8, 4, 4);
    ramp(8'h46, 4, 8, 3);
    ramp(8'h10, 4, 8, 4);
    chk(APPLIED_CODE, 8'h36);
    apb(1'b1, `DVR_OFF_RAMP, 32'hB0);
    ramp(8'h60, 1, 8, 2);
    // still short of the goal, so status must report a normal fall
    apb(1'b0, `DVR_OFF_STATUS, 32'h0);
    chk(rd, 32'h02);
    // instant fall mutes outright, whatever the goal
    apb(1'b1, `DVR_OFF_RAMP, 32'hC0);
    apb(1'b1, `DVR_OFF_LEVEL, 32'h70);
    st(8'hFF, 255);
    chk(APPLIED_CODE, `DVR_CODE_MUTE);
    apb(1'b1, `DVR_OFF_RAMP, 32'h3C);
    st(8'h70, 255);
    chk(APPLIED_CODE, 8'h70);
    $display("t_ramp done");
  endtask

  // normal fall is one code a step here, so a 4-code move proves the separate setting
  task automatic t_emerg();
    apb(1'b1, `DVR_OFF_EMERG, 32'h10);
    EMERGENCY <= 1'b1;
    repeat (3) @(posedge CLK);
    mv = 0;
    repeat (3) st(8'hFF, 4);
    chk(mv, 3);
    chk(APPLIED_CODE, 8'h7C);
    apb(1'b0, `DVR_OFF_STATUS, 32'h0);
    chk(rd, 32'h03);
    apb(1'b1, `DVR_OFF_EMERG, 32'hC0);
    st(8'hFF, 255);
    chk(APPLIED_CODE, `DVR_CODE_MUTE);
    EMERGENCY <= 1'b0;
    repeat (3) @(posedge CLK);
    st(8'h70, 255);
    chk(APPLIED_CODE, 8'h70);
    $display("t_emerg done");
  endtask

  task automatic t_silence();
    LEFT_IN <= 24'h0;
    repeat (1103) tick();
    apb(1'b1, `DVR_OFF_SILENCE, 32'h03);
    chk(LEFT_SILENT, 1'b0);
    tick();
    chk({LEFT_SILENT, RIGHT_SILENT}, 2'b10);
    apb(1'b1, `DVR_OFF_SILENCE, 32'h07);
    repeat (2) @(posedge CLK);
    chk(LEFT_SILENT, 1'b0);
    apb(1'b1, `DVR_OFF_SILENCE, 32'h02);
    RIGHT_IN <= 24'h0;
    repeat (1104) tick();
    chk({LEFT_SILENT, RIGHT_SILENT}, 2'b01);
    apb(1'b1, `DVR_OFF_SILENCE, 32'h07);
    repeat (2) @(posedge CLK);
    chk({LEFT_SILENT, RIGHT_SILENT}, 2'b11);
    LEFT_IN <= 24'h10;
    tick();
    chk({LEFT_SILENT, RIGHT_SILENT}, 2'b00);
    $display("t_silence done");
  endtask

  // main sequence; nonzero samples keep silence idle during the ramp tests
  initial
  begin
    {PSEL, PENABLE, PWRITE, SAMPLE_TICK, EMERGENCY} = 5'h0;
    PADDR = 10'h000;
    PWDATA = 32'h0;
    LEFT_IN = 24'h1;
    RIGHT_IN = 24'h1;
    mismatches = 0;
    checks = 0;
    RST = 1'b1;
    repeat (10) @(posedge CLK);
    RST <= 1'b0;
    @(posedge CLK);
    t_regs();
    t_ramp();
    t_emerg();
    t_silence();
    print_verdict();
  end
endmodule
`default_nettype wire
